// ---- design/rcd_pkg.sv ----
// Purpose: Shared constants and types of the reference clock divider
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   Divider select is {ctrl4[1], ctrl2[6], ctrl2[5]}
package rcd_pkg;

  localparam int             AXI_AW        = 8;
  localparam logic [7:0]     OFS_CTRL2     = 8'h00;
  localparam logic [7:0]     OFS_CTRL4     = 8'h04;
  localparam logic [7:0]     OFS_AUX       = 8'h08;
  localparam logic [7:0]     OFS_PINSEL    = 8'h0c;
  localparam logic [7:0]     OFS_STATUS    = 8'h10;

  localparam logic [1:0]     RESP_OKAY     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR   = 2'h2;

  localparam int             CTRL2_SEL0    = 5;
  localparam int             CTRL2_SEL1    = 6;
  localparam int             CTRL4_SEL2    = 1;
  localparam int             AUX_REF_BIT   = 1;
  localparam int             AUX_IF_BIT    = 3;
  localparam int             PINSEL_REF    = 0;
  localparam int             PINSEL_IF     = 1;
  localparam int             STAT_INVALID  = 4;
  localparam int             STAT_CLK      = 5;

  localparam logic [7:0]     CTRL2_RST     = 8'h00;
  localparam logic [7:0]     CTRL4_RST     = 8'h00;
  localparam logic [7:0]     AUX_RST       = 8'h00;
  localparam logic [1:0]     PINSEL_RST    = 2'h0;

  // Internal clock and the data bit rate derived from it
  localparam int             INT_CLK_KHZ   = 2560;
  localparam int             BIT_RATE_BPS  = 10000;
  localparam int             BIT_DIV       = (INT_CLK_KHZ * 1000) / BIT_RATE_BPS;

  // Reference frequencies in kHz for each select code
  localparam int             REF0_KHZ      = 2560;
  localparam int             REF1_KHZ      = 5120;
  localparam int             REF2_KHZ      = 7680;
  localparam int             REF3_KHZ      = 10240;
  localparam int             REF4_KHZ      = 15360;
  localparam int             REF5_KHZ      = 20480;

  function automatic logic [3:0] rcd_ratio(input logic [2:0] sel);
    int khz;
    khz = REF0_KHZ;
    unique case (sel)
      3'h1:    khz = REF1_KHZ;
      3'h2:    khz = REF2_KHZ;
      3'h3:    khz = REF3_KHZ;
      3'h4:    khz = REF4_KHZ;
      3'h5:    khz = REF5_KHZ;
      default: khz = REF0_KHZ;
    endcase
    return 4'(khz / INT_CLK_KHZ);
  endfunction : rcd_ratio

  function automatic logic rcd_sel_invalid(input logic [2:0] sel);
    return (sel > 3'h5);
  endfunction : rcd_sel_invalid

  typedef struct packed {
    logic                    osc_prev;
    logic [3:0]              half_cnt;
    logic                    int_clk;
    logic                    int_tick;
  } rcd_div_s;

  localparam rcd_div_s       DIV_RST       = '0;

  typedef struct packed {
    logic                    aw_have;
    logic [AXI_AW-1:0]       aw_addr;
    logic                    w_have;
    logic [7:0]              w_data;
    logic                    w_strb0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [7:0]              ctrl2;
    logic [7:0]              ctrl4;
    logic [7:0]              aux;
    logic [1:0]              pinsel;
    logic [15:0]             bit_cnt;
    logic                    bit_tick;
    logic                    ref_pin;
    logic                    if_pin;
    logic                    osc_drv;
  } rcd_top_s;

  localparam rcd_top_s       TOP_RST       = '{ctrl2: CTRL2_RST, ctrl4: CTRL4_RST,
                                             aux: AUX_RST, pinsel: PINSEL_RST,
                                             default: '0};

endpackage : rcd_pkg

// ---- design/rcd_if.sv ----
// Purpose: Link between the register side and the edge divider
// Assumes: One clock domain
// Notes:   Ratio counts reference half periods per internal half period
`timescale 1ns/1ps
interface rcd_if;
  logic [3:0] ratio;
  logic       ref_level;
  logic       int_clk;
  logic       int_tick;

  modport ctl (output ratio, output ref_level, input int_clk, input int_tick);
  modport div (input ratio, input ref_level, output int_clk, output int_tick);
endinterface : rcd_if

// ---- design/rcd_divider.sv ----
// Purpose: Divide the sampled reference down to the 2.56 MHz internal clock
// Assumes: Reference sampled at clk is far below clk/2 (20.48 MHz at 250 MHz)
// Notes:   Ratio 1 passes the reference edges straight through
`timescale 1ns/1ps
module rcd_divider
(
  input  wire logic clk,
  input  wire logic nrst,
  rcd_if.div        dv
);

  rcd_pkg::rcd_div_s s_reg;
  rcd_pkg::rcd_div_s s_next;

  always_comb
  begin
    s_next          = s_reg;
    s_next.int_tick = 1'b0;
    s_next.osc_prev = dv.ref_level;
    if (dv.ref_level != s_reg.osc_prev)
    begin
      // Comparing with >= lets a ratio change mid-count settle at once
      if (s_reg.half_cnt + 4'h1 >= dv.ratio)
      begin
        s_next.half_cnt = 4'h0;
        s_next.int_clk  = ~s_reg.int_clk;
        s_next.int_tick = ~s_reg.int_clk;
      end
      else
      begin
        s_next.half_cnt = s_reg.half_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_reg <= rcd_pkg::DIV_RST;
    else
      s_reg <= s_next;
  end

  assign dv.int_clk  = s_reg.int_clk;
  assign dv.int_tick = s_reg.int_tick;

endmodule : rcd_divider

// ---- design/rcd_top.sv ----
// Purpose: Reference clock divider with AXI4-Lite control registers
// Assumes: osc_in is synchronous to clk; one write and one read at a time
// Notes:   Pin outputs are registered, so they lag the internal clock by one cycle
//          A new select takes effect at once; the divider picks up at its next edge
//          Bit timing is only as accurate as the reference, by design
//
// How it works
// - Crystal references 2.56 to 10.24 MHz divided
// - External references 15.36, 20.48 MHz also divided
// - Reset selects 2.56 MHz, no division
// - Clock output pin 2.56 MHz unless pinsel bit 0 selects aux
// - Clock output pin may carry aux bit 1
// - Interface clock pin may carry aux bit 3
// - Low reset loads every default setting
// - Bit rate timing derived from divided clock
`timescale 1ns/1ps
module rcd_top
#(
  parameter int BIT_DIV = rcd_pkg::BIT_DIV
)
(
  input  wire logic                      clk,
  input  wire logic                      nrst,

  // Write address and write data channels
  input  wire logic [rcd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,

  // Write response channel
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,

  // Read address and read data channels
  input  wire logic [rcd_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,

  // Reference oscillator pins
  input  wire logic                      osc_in,
  output logic                           osc_out,

  // Clock pins, output port and timing pulses
  output logic                           ref_clock_out,
  output logic                           if_clock_out,
  output logic [7:0]                     aux_output_port,
  output logic                           int_clk_tick,
  output logic                           bit_rate_tick
);

  rcd_pkg::rcd_top_s s_reg;
  rcd_pkg::rcd_top_s s_next;
  rcd_if             dv ();
  // Select code is {ctrl4 bit 1, ctrl2 bit 6, ctrl2 bit 5}
  logic [2:0]        div_sel;

  // Edge counter that makes the internal clock from the sampled reference
  rcd_divider u_div
  (
    .clk  (clk),
    .nrst (nrst),
    .dv   (dv.div)
  );

  assign div_sel      = {s_reg.ctrl4[rcd_pkg::CTRL4_SEL2],
                         s_reg.ctrl2[rcd_pkg::CTRL2_SEL1],
                         s_reg.ctrl2[rcd_pkg::CTRL2_SEL0]};
  assign dv.ratio     = rcd_pkg::rcd_ratio(div_sel);
  assign dv.ref_level = osc_in;

  localparam int AXI_AW_F = rcd_pkg::AXI_AW;

  // Registers are whole words, so the two low address bits are ignored
  function automatic logic [AXI_AW_F-1:0] word_addr(input logic [AXI_AW_F-1:0] a);
    return {a[AXI_AW_F-1:2], 2'b00};
  endfunction : word_addr

  always_comb
  begin
    s_next          = s_reg;
    s_next.bit_tick = 1'b0;

    // Address and data are captured on their own, in either order
    if (!s_reg.aw_have && s_axi_awvalid)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (!s_reg.w_have && s_axi_wvalid)
    begin
      s_next.w_have  = 1'b1;
      s_next.w_data  = s_axi_wdata[7:0];
      s_next.w_strb0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;

    // A write commits only once address and data are both held
    // A pending response holds the commit back, so responses never merge
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = rcd_pkg::RESP_OKAY;
      unique case (word_addr(s_reg.aw_addr))
        rcd_pkg::OFS_CTRL2:
          if (s_reg.w_strb0)
            s_next.ctrl2 = s_reg.w_data;
        rcd_pkg::OFS_CTRL4:
          if (s_reg.w_strb0)
            s_next.ctrl4 = s_reg.w_data;
        rcd_pkg::OFS_AUX:
          if (s_reg.w_strb0)
            s_next.aux = s_reg.w_data;
        rcd_pkg::OFS_PINSEL:
          if (s_reg.w_strb0)
            s_next.pinsel = s_reg.w_data[1:0];
        rcd_pkg::OFS_STATUS:
          // Status is read-only: the write is accepted and dropped
          s_next.bresp = rcd_pkg::RESP_OKAY;
        default:
          s_next.bresp = rcd_pkg::RESP_SLVERR;
      endcase
    end

    // A read is answered from the registers as they stand when it is taken
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (!s_reg.rvalid && s_axi_arvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = rcd_pkg::RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      unique case (word_addr(s_axi_araddr))
        rcd_pkg::OFS_CTRL2:
          s_next.rdata[7:0] = s_reg.ctrl2;
        rcd_pkg::OFS_CTRL4:
          s_next.rdata[7:0] = s_reg.ctrl4;
        rcd_pkg::OFS_AUX:
          s_next.rdata[7:0] = s_reg.aux;
        rcd_pkg::OFS_PINSEL:
          s_next.rdata[1:0] = s_reg.pinsel;
        rcd_pkg::OFS_STATUS:
        begin
          s_next.rdata[3:0]                   = dv.ratio;
          s_next.rdata[rcd_pkg::STAT_INVALID] = rcd_pkg::rcd_sel_invalid(div_sel);
          s_next.rdata[rcd_pkg::STAT_CLK]     = dv.int_clk;
        end
        default:
          // Unmapped reads give zero data with an error response
          s_next.rresp = rcd_pkg::RESP_SLVERR;
      endcase
    end

    // Bit timing counts internal clock periods, so it inherits reference accuracy
    // A select change mid-bit disturbs only the bit in which it falls
    if (dv.int_tick)
    begin
      if (s_reg.bit_cnt >= 16'(BIT_DIV - 1))
      begin
        s_next.bit_cnt  = 16'h0000;
        s_next.bit_tick = 1'b1;
      end
      else
      begin
        s_next.bit_cnt = s_reg.bit_cnt + 16'h0001;
      end
    end

    // Pins are registered so a select change cannot glitch them
    if (s_reg.pinsel[rcd_pkg::PINSEL_REF])
      s_next.ref_pin = s_reg.aux[rcd_pkg::AUX_REF_BIT];
    else
      s_next.ref_pin = dv.int_clk;
    if (s_reg.pinsel[rcd_pkg::PINSEL_IF])
      s_next.if_pin = s_reg.aux[rcd_pkg::AUX_IF_BIT];
    else
      s_next.if_pin = dv.int_clk;

    // Crystal drive is the inverted input, as an inverting amplifier gives
    s_next.osc_drv = ~osc_in;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg <= rcd_pkg::TOP_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Handshake outputs come straight from the holding flags
  assign s_axi_awready   = !s_reg.aw_have;
  assign s_axi_wready    = !s_reg.w_have;
  assign s_axi_bvalid    = s_reg.bvalid;
  assign s_axi_bresp     = s_reg.bresp;
  assign s_axi_arready   = !s_reg.rvalid;
  assign s_axi_rvalid    = s_reg.rvalid;
  assign s_axi_rdata     = s_reg.rdata;
  assign s_axi_rresp     = s_reg.rresp;

  // Pins and pulses, all from flip-flops
  assign osc_out         = s_reg.osc_drv;
  assign ref_clock_out   = s_reg.ref_pin;
  assign if_clock_out    = s_reg.if_pin;
  assign aux_output_port = s_reg.aux;
  assign int_clk_tick    = dv.int_tick;
  assign bit_rate_tick   = s_reg.bit_tick;

endmodule : rcd_top

// ---- sim/rcd_top_props.sv ----
// Purpose: Port-level properties of the reference clock divider
// Assumes: Bound into rcd_top, one clock domain
// Notes:   Tick counter judges the bit rate against the divided clock
`timescale 1ns/1ps
module rcd_top_props
#(
  parameter int BIT_DIV = rcd_pkg::BIT_DIV
)
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        osc_in,
  input wire logic        osc_out,
  input wire logic        ref_clock_out,
  input wire logic [7:0]  aux_output_port,
  input wire logic        int_clk_tick,
  input wire logic        bit_rate_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic [15:0] tick_cnt;
  logic        bit_seen;

  // First window after reset has no known start, so it is not judged
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_cnt <= 16'h0000;
      bit_seen <= 1'b0;
    end
    else if (bit_rate_tick)
    begin
      tick_cnt <= 16'h0000;
      bit_seen <= 1'b1;
    end
    else
      tick_cnt <= tick_cnt + 16'(int_clk_tick);
  end

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence commit_seen;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid && s_axi_awready;
  endsequence

  a_write_walk: assert property (both_taken |=> commit_seen)
    else $error("write response out of step");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_osc_invert: assert property (1'b1 |=> osc_out == !$past(osc_in))
    else $error("oscillator drive wrong");
  a_tick_pulse: assert property (int_clk_tick |=> !int_clk_tick)
    else $error("internal tick too long");
  a_bit_rate: assert property (bit_rate_tick && bit_seen |-> tick_cnt + 16'(int_clk_tick) == 16'(BIT_DIV))
    else $error("bit rate not tied to internal clock");
  a_rst_defaults: assert property ($rose(nrst) |-> !ref_clock_out && !s_axi_bvalid && aux_output_port == 8'h00)
    else $error("outputs not at defaults after reset");
endmodule : rcd_top_props

bind rcd_top rcd_top_props #(.BIT_DIV(BIT_DIV)) u_props (.*);

// ---- sim/rcd_audio_model.sv ----
// Purpose: Companion processor side, measures the clock it receives
// Assumes: Received clock is far slower than clk
// Notes:   Period is in clk cycles between rising edges
`timescale 1ns/1ps
module rcd_audio_model
(
  input wire logic   clk,
  input wire logic   nrst,
  input wire logic   hclk,
  output logic [15:0] period
);
  logic        hclk_d;
  logic [15:0] cnt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hclk_d <= 1'b0;
      cnt    <= 16'h0000;
      period <= 16'h0000;
    end
    else
    begin
      hclk_d <= hclk;
      cnt    <= (hclk && !hclk_d) ? 16'h0000 : cnt + 16'h0001;
      if (hclk && !hclk_d)
        period <= cnt + 16'h0001;
    end
  end
endmodule : rcd_audio_model

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench of the reference clock divider
// Assumes: BIT_DIV shortened to 4; all references give a 48-cycle output
// Notes:   Reference half period is 24/ratio cycles, so the output stays fixed
`timescale 1ns/1ps
module testbench;
  logic              clk, nrst, osc_in;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, aux_output_port;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic [31:0]       s_axi_wdata, s_axi_rdata, q;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              osc_out, ref_clock_out, if_clock_out, int_clk_tick, bit_rate_tick;
  logic [15:0]       ref_per, if_per;
  int                err_count, check_count, osc_half, osc_cnt, span, ticks;
  int                half_tab [8] = '{24, 12, 8, 6, 4, 3, 24, 24};
  logic [4:0]        stat_tab [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h11, 5'h11};

  rcd_top #(.BIT_DIV(4)) DUT (.*);
  rcd_audio_model u_ref (.clk, .nrst, .hclk(ref_clock_out), .period(ref_per));
  rcd_audio_model u_if (.clk, .nrst, .hclk(if_clock_out), .period(if_per));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    osc_cnt <= (osc_cnt >= osc_half - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt >= osc_half - 1)
      osc_in <= ~osc_in;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk

  // Bready or rready goes up with the request and stays up until the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    kb = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_arvalid <= !w;
    s_axi_bready  <= w;
    s_axi_rready  <= !w;
    while (!kb)
    begin
      // Settled values at the falling edge are what the next rising edge samples
      @(negedge clk);
      ka = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      kw = s_axi_wvalid && s_axi_wready;
      kb = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      r  = w ? s_axi_bresp : s_axi_rresp;
      q  = s_axi_rdata;
      @(posedge clk);
      if (ka)
        {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (kw)
        s_axi_wvalid <= 1'b0;
      if (kb)
        {s_axi_bready, s_axi_rready} <= 2'b00;
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bus(1'b1, a, d);
    chk("bresp", 32'(er), 32'(r));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", e, q & m);
  endtask : rd

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Run needs about 2400 cycles; the limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {nrst, osc_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {err_count, check_count, osc_cnt} = '0;
    osc_half = 24;
    do_reset();
    rd(rcd_pkg::OFS_STATUS, 32'h1f, 32'h01, rcd_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      osc_half = half_tab[i];
      wr(rcd_pkg::OFS_CTRL2, 32'(i[1:0]) << 5, rcd_pkg::RESP_OKAY);
      wr(rcd_pkg::OFS_CTRL4, 32'(i[2]) << 1, rcd_pkg::RESP_OKAY);
      rd(rcd_pkg::OFS_STATUS, 32'h1f, 32'(stat_tab[i]), rcd_pkg::RESP_OKAY);
      repeat (200) @(posedge clk);
      chk("ref_period", 32'h30, 32'(ref_per));
      chk("if_period", 32'h30, 32'(if_per));
    end
    wr(rcd_pkg::OFS_AUX, 32'h0a, rcd_pkg::RESP_OKAY);
    wr(rcd_pkg::OFS_PINSEL, 32'h03, rcd_pkg::RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("pins", 32'h30a, 32'({ref_clock_out, if_clock_out, aux_output_port}));
    wr(rcd_pkg::OFS_AUX, 32'h08, rcd_pkg::RESP_OKAY);
    wr(rcd_pkg::OFS_PINSEL, 32'h01, rcd_pkg::RESP_OKAY);
    repeat (200) @(posedge clk);
    chk("ref_pin", 32'h0, 32'(ref_clock_out));
    chk("if_period", 32'h30, 32'(if_per));
    // A stalled master must find the read answer still standing
    @(posedge clk);
    s_axi_araddr  <= rcd_pkg::OFS_AUX;
    s_axi_arvalid <= 1'b1;
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("stalled_read", 32'h208, 32'({s_axi_rvalid, s_axi_arready, s_axi_rdata[7:0]}));
    @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    @(negedge clk);
    chk("read_release", 32'h1, 32'({s_axi_rvalid, s_axi_arready}));
    // Crystal drive is the inverted reference, one cycle late
    @(negedge clk iff osc_cnt == 5);
    chk("osc_out", 32'(!osc_in), 32'(osc_out));
    // One bit spans BIT_DIV (4) internal periods of 48 cycles
    @(negedge clk iff bit_rate_tick);
    span = 0;
    ticks = 0;
    do
    begin
      @(negedge clk);
      span++;
      ticks += int'(int_clk_tick);
    end
    while (!bit_rate_tick);
    chk("bit_span", 32'hc0, 32'(span));
    chk("int_ticks", 32'h4, 32'(ticks));
    wr(8'h14, 32'hff, rcd_pkg::RESP_SLVERR);
    rd(8'h14, 32'hffffffff, 32'h0, rcd_pkg::RESP_SLVERR);
    wr(rcd_pkg::OFS_STATUS, 32'hff, rcd_pkg::RESP_OKAY);
    rd(rcd_pkg::OFS_STATUS, 32'h1f, 32'h11, rcd_pkg::RESP_OKAY);
    do_reset();
    rd(rcd_pkg::OFS_CTRL4, 32'hff, 32'h00, rcd_pkg::RESP_OKAY);
    rd(rcd_pkg::OFS_PINSEL, 32'hff, 32'h00, rcd_pkg::RESP_OKAY);
    rd(rcd_pkg::OFS_STATUS, 32'h1f, 32'h01, rcd_pkg::RESP_OKAY);
    wrap_up();
  end
endmodule : testbench
